// file: logic/host_port_memory.sv
// on-chip word memory reached through the host port
module host_port_memory (
	// clock
	input  wire logic                                     i_clk,
	// write side
	input  wire logic                                     i_we,
	input  wire logic [pin_mode_pkg::MEM_AW-1:0]          i_waddr,
	input  wire logic [pin_mode_pkg::HOST_W-1:0]          i_wdata,
	// read side
	input  wire logic                                     i_re,
	input  wire logic [pin_mode_pkg::MEM_AW-1:0]          i_raddr,
	output logic      [pin_mode_pkg::HOST_W-1:0]          o_rdata
);
	import pin_mode_pkg::*;

	logic [HOST_W-1:0] mem [0:(1<<MEM_AW)-1];

	// write port and registered read port
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		if (i_re) begin
			o_rdata <= mem[i_raddr];
		end
	end

endmodule : host_port_memory

// file: logic/memory_host_pin_mode_mux.sv
// memory pin personality select: external memory bus or host memory port
module memory_host_pin_mode_mux (
	// clock and reset
	input  wire logic                                  i_clk,
	input  wire logic                                  i_nrst,
	// straps
	input  wire logic                                  i_memory_mode_strap,
	input  wire logic                                  i_ack_push_pull_strap,
	// core external access request
	input  wire logic                                  i_core_req,
	input  wire logic                                  i_core_write,
	input  wire pin_mode_pkg::space_t                  i_core_space,
	input  wire logic [pin_mode_pkg::ADDR_W-1:0]       i_core_addr,
	input  wire logic [pin_mode_pkg::DATA_W-1:0]       i_core_wdata,
	input  wire logic [pin_mode_pkg::BYTE_W-1:0]       i_core_byte_page,
	output logic                                       o_core_done,
	output logic      [pin_mode_pkg::DATA_W-1:0]       o_core_rdata,
	// external memory bus
	output logic      [pin_mode_pkg::ADDR_W-1:0]       o_external_address_out,
	output logic      [pin_mode_pkg::ADDR_W-1:0]       o_external_address_oe,
	input  wire logic [pin_mode_pkg::DATA_W-1:0]       i_external_data_bus,
	output logic      [pin_mode_pkg::DATA_W-1:0]       o_external_data_bus,
	output logic      [pin_mode_pkg::DATA_W-1:0]       o_external_data_oe,
	// space selects and strobes, active low
	output logic                                       o_combined_space_select_n,
	output logic                                       o_program_space_select_n,
	output logic                                       o_data_space_select_n,
	output logic                                       o_byte_space_select_n,
	output logic                                       o_io_space_select_n,
	output logic                                       o_rd_n,
	output logic                                       o_wr_n,
	output logic                                       o_strobe_oe,
	// bus arbitration
	input  wire logic                                  i_bus_request_in_n,
	input  wire logic                                  i_emulator_bus_request_n,
	input  wire logic                                  i_emulator_enable,
	output logic                                       o_bus_grant_out_n,
	output logic                                       o_bus_grant_oe,
	output logic                                       o_bus_grant_hang_out_n,
	// host memory port
	input  wire logic [pin_mode_pkg::HOST_W-1:0]       i_host_addr_data_bus,
	output logic      [pin_mode_pkg::HOST_W-1:0]       o_host_addr_data_bus,
	output logic                                       o_host_addr_data_oe,
	input  wire logic                                  i_host_select_n,
	input  wire logic                                  i_host_write_strobe_n,
	input  wire logic                                  i_host_read_strobe_n,
	input  wire logic                                  i_host_addr_latch,
	output logic                                       o_host_ack_n,
	output logic                                       o_host_ack_oe,
	// flags, clock out, serial enables
	input  wire logic [pin_mode_pkg::FLAG_W-1:0]       i_flag_pins,
	output logic      [pin_mode_pkg::FLAG_W-1:0]       o_flag_pins,
	output logic      [pin_mode_pkg::FLAG_W-1:0]       o_flag_oe,
	output logic                                       o_processor_clock_output,
	output logic                                       o_serial_out_oe,
	output logic                                       o_host_mode,
	// register port
	input  wire logic [pin_mode_pkg::REG_AW-1:0]       i_reg_addr,
	input  wire logic [pin_mode_pkg::FLAG_W-1:0]       i_reg_wdata,
	input  wire logic                                  i_reg_wr,
	input  wire logic                                  i_reg_rd,
	output logic      [pin_mode_pkg::FLAG_W-1:0]       o_reg_rdata
);
	import pin_mode_pkg::*;

	// active-low selects {combined, program, data, byte, io}
	function automatic logic [4:0] space_selects(input space_t sp);
		logic [4:0] s;
		s = 5'h1F;
		case (sp)
			SP_PROGRAM: s = 5'h07;
			SP_DATA:    s = 5'h0B;
			SP_BYTE:    s = 5'h1D;
			SP_IO:      s = 5'h0E;
			default:    s = 5'h1F;
		endcase
		return s;
	endfunction : space_selects

	//--------------------------------------------------------------
	// mode strap capture
	//--------------------------------------------------------------
	logic  mode_locked_q, mode_locked_d;
	mode_t mode_q, mode_d;
	logic  ack_pp_q, ack_pp_d;
	logic  host;

	// strap sampled once at the first edge after reset release
	always_comb begin
		mode_locked_d = 1'b1;
		mode_d        = mode_q;
		ack_pp_d      = ack_pp_q;
		if (!mode_locked_q) begin
			mode_d   = mode_t'(i_memory_mode_strap);
			ack_pp_d = i_ack_push_pull_strap;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			mode_locked_q <= 1'b0;
			mode_q        <= MODE_FULL;
			ack_pp_q      <= 1'b0;
		end else begin
			mode_locked_q <= mode_locked_d;
			mode_q        <= mode_d;
			ack_pp_q      <= ack_pp_d;
		end
	end

	assign host        = mode_locked_q && (mode_q == MODE_HOST);
	assign o_host_mode = host;

	//--------------------------------------------------------------
	// external bus sequencer and arbitration
	//--------------------------------------------------------------
	bus_state_t           state_q, state_d;
	logic [2:0]           cnt_q, cnt_d;
	logic [ADDR_W-1:0]    addr_q, addr_d;
	logic [DATA_W-1:0]    dout_q, dout_d, rdata_q, rdata_d;
	logic [4:0]           sel_q, sel_d;
	logic                 write_q, write_d, byte_q, byte_d, done_q, done_d;
	logic                 bus_req;

	assign bus_req = !i_bus_request_in_n || !i_emulator_bus_request_n;

	// next state of the access and grant sequence
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		addr_d  = addr_q;
		dout_d  = dout_q;
		sel_d   = sel_q;
		write_d = write_q;
		byte_d  = byte_q;
		rdata_d = rdata_q;
		done_d  = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (bus_req && mode_locked_q) begin
					state_d = ST_GRANT;
				end else if (i_core_req && mode_locked_q) begin
					state_d = ST_ACCESS;
					cnt_d   = ACCESS_CYCLES - 3'h1;
					addr_d  = i_core_addr;
					write_d = i_core_write;
					byte_d  = (i_core_space == SP_BYTE);
					sel_d   = space_selects(i_core_space);
					dout_d  = i_core_wdata;
					if (i_core_space == SP_BYTE) begin
						dout_d[DATA_W-1 -: BYTE_W] = i_core_byte_page;
					end
				end
			end
			ST_ACCESS: begin
				if (cnt_q == 3'h0) begin
					state_d = ST_IDLE;
					done_d  = 1'b1;
					sel_d   = 5'h1F;
					rdata_d = i_external_data_bus;
				end else begin
					cnt_d = cnt_q - 3'h1;
				end
			end
			ST_GRANT: begin
				if (!bus_req) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= ST_IDLE;
			cnt_q   <= 3'h0;
			addr_q  <= '0;
			dout_q  <= '0;
			sel_q   <= 5'h1F;
			write_q <= 1'b0;
			byte_q  <= 1'b0;
			rdata_q <= '0;
			done_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			addr_q  <= addr_d;
			dout_q  <= dout_d;
			sel_q   <= sel_d;
			write_q <= write_d;
			byte_q  <= byte_d;
			rdata_q <= rdata_d;
			done_q  <= done_d;
		end
	end

	// pin drive: floats at reset and under grant, host mode keeps address bit 0 and data bits 23:8 only
	always_comb begin
		o_external_address_oe = '0;
		o_external_data_oe    = '0;
		if (state_q == ST_ACCESS) begin
			o_external_address_oe = host ? {{(ADDR_W-1){1'b0}}, 1'b1} : {ADDR_W{1'b1}};
			if (write_q) begin
				o_external_data_oe[DATA_W-1:BYTE_W] = {(DATA_W-BYTE_W){1'b1}};
				o_external_data_oe[BYTE_W-1:0]      = {BYTE_W{!host}};
			end else if (byte_q) begin
				o_external_data_oe[DATA_W-1 -: BYTE_W] = {BYTE_W{1'b1}};
			end
		end
	end

	assign o_external_address_out    = addr_q;
	assign o_external_data_bus       = dout_q;
	assign o_combined_space_select_n = sel_q[4];
	assign o_program_space_select_n  = sel_q[3];
	assign o_data_space_select_n     = sel_q[2];
	assign o_byte_space_select_n     = sel_q[1];
	assign o_io_space_select_n       = sel_q[0];
	assign o_rd_n                    = !((state_q == ST_ACCESS) && !write_q);
	assign o_wr_n                    = !((state_q == ST_ACCESS) && write_q);
	assign o_strobe_oe               = (state_q != ST_GRANT);
	assign o_bus_grant_out_n         = (state_q != ST_GRANT);
	assign o_bus_grant_oe            = !i_emulator_enable;
	assign o_bus_grant_hang_out_n    = !((state_q == ST_GRANT) && i_core_req);
	assign o_core_done               = done_q;
	assign o_core_rdata              = rdata_q;
	assign o_serial_out_oe           = 1'b1;

	//--------------------------------------------------------------
	// host memory port
	//--------------------------------------------------------------
	logic [HOST_LATCH_W-1:0] haddr_q, haddr_d;
	logic                    wr_prev_q, rd_prev_q, busy_q, busy_d;
	logic                    hwr_go, hrd_go, hsel;
	logic [MEM_AW-1:0]       hidx;
	logic [HOST_W-1:0]       mem_rdata;

	assign hsel   = host && !i_host_select_n;
	assign hwr_go = hsel && wr_prev_q && !i_host_write_strobe_n;
	assign hrd_go = hsel && rd_prev_q && !i_host_read_strobe_n;
	assign hidx   = {haddr_q[HOST_SPACE_BIT], haddr_q[MEM_AW-2:0]};

	// address latch, auto-increment after each word, ack busy flag
	always_comb begin
		haddr_d = haddr_q;
		busy_d  = hwr_go || hrd_go;
		if (hsel && i_host_addr_latch) begin
			haddr_d = i_host_addr_data_bus[HOST_LATCH_W-1:0];
		end else if (hwr_go || hrd_go) begin
			haddr_d = {haddr_q[HOST_SPACE_BIT], haddr_q[HOST_SPACE_BIT-1:0] + 14'h0001};
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			haddr_q   <= '0;
			wr_prev_q <= 1'b1;
			rd_prev_q <= 1'b1;
			busy_q    <= 1'b0;
		end else begin
			haddr_q   <= haddr_d;
			wr_prev_q <= i_host_write_strobe_n;
			rd_prev_q <= i_host_read_strobe_n;
			busy_q    <= busy_d;
		end
	end

	host_port_memory u_mem (
		.i_clk   (i_clk),
		.i_we    (hwr_go),
		.i_waddr (hidx),
		.i_wdata (i_host_addr_data_bus),
		.i_re    (hrd_go),
		.i_raddr (hidx),
		.o_rdata (mem_rdata)
	);

	assign o_host_addr_data_bus = mem_rdata;
	assign o_host_addr_data_oe  = hsel && !i_host_read_strobe_n && !busy_q;
	assign o_host_ack_n         = !(hsel && !busy_q);
	assign o_host_ack_oe        = host && (ack_pp_q || !o_host_ack_n);

	//--------------------------------------------------------------
	// control registers
	//--------------------------------------------------------------
	logic [FLAG_W-1:0] dir_q, dir_d, fout_q, fout_d, rd_q, rd_d;
	logic              clken_q, clken_d, clk_div_q, clk_div_d;

	// register writes, registered readback
	always_comb begin
		dir_d     = dir_q;
		fout_d    = fout_q;
		clken_d   = clken_q;
		rd_d      = rd_q;
		clk_div_d = clken_q ? !clk_div_q : 1'b0;
		if (i_reg_wr) begin
			case (i_reg_addr)
				OFS_CTRL:     clken_d = i_reg_wdata[CTRL_PROCESSOR_CLOCK_OUTPUT_BIT];
				OFS_FLAG_DIR: dir_d   = i_reg_wdata;
				OFS_FLAG_OUT: fout_d  = i_reg_wdata;
				default:      clken_d = clken_q;
			endcase
		end
		if (i_reg_rd) begin
			rd_d = '0;
			case (i_reg_addr)
				OFS_CTRL:     rd_d[CTRL_PROCESSOR_CLOCK_OUTPUT_BIT] = clken_q;
				OFS_FLAG_DIR: rd_d = dir_q;
				OFS_FLAG_OUT: rd_d = fout_q;
				OFS_STATUS: begin
					rd_d[STAT_MODE_BIT]  = mode_q;
					rd_d[STAT_GRANT_BIT] = !o_bus_grant_out_n;
					rd_d[STAT_HANG_BIT]  = !o_bus_grant_hang_out_n;
				end
				OFS_FLAG_IN:  rd_d = i_flag_pins;
				default:      rd_d = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			dir_q     <= FLAG_DIR_RST;
			fout_q    <= FLAG_OUT_RST;
			clken_q   <= PROCESSOR_CLOCK_OUTPUT_EN_RST;
			rd_q      <= '0;
			clk_div_q <= 1'b0;
		end else begin
			dir_q     <= dir_d;
			fout_q    <= fout_d;
			clken_q   <= clken_d;
			rd_q      <= rd_d;
			clk_div_q <= clk_div_d;
		end
	end

	assign o_flag_oe                = dir_q;
	assign o_flag_pins              = fout_q;
	assign o_processor_clock_output = clk_div_q;
	assign o_reg_rdata              = rd_q;

	//--------------------------------------------------------------
	// checks
	//--------------------------------------------------------------
	a_mode_held: assert property (@(posedge i_clk) disable iff (!i_nrst)
		mode_locked_q |=> $stable(mode_q)) else $error("mode changed after reset");
	a_full_addr_drive: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(state_q == ST_ACCESS && !host) |-> (o_external_address_oe == {ADDR_W{1'b1}}))
		else $error("full mode address not driven");
	a_host_addr_bit: assert property (@(posedge i_clk) disable iff (!i_nrst)
		host |-> (o_external_address_oe[ADDR_W-1:1] == '0 && o_external_data_oe[BYTE_W-1:0] == '0))
		else $error("host mode drives removed pins");
	a_grant_float: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!o_bus_grant_out_n |-> (!o_strobe_oe && o_external_address_oe == '0 && o_external_data_oe == '0))
		else $error("pins driven during grant");
	a_grant_follows: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(state_q == ST_IDLE && bus_req && mode_locked_q) |=> !o_bus_grant_out_n)
		else $error("bus request not granted");
	a_host_unselected: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_host_select_n |-> !o_host_addr_data_oe) else $error("host bus driven while unselected");
	a_flags_input: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(mode_locked_q) |-> (o_flag_oe == '0 && o_external_data_oe == '0))
		else $error("flags or data not floating after reset");
	a_processor_clock_output_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!clken_q [*2] |-> !o_processor_clock_output) else $error("clock output not stopped");
	a_access_len: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(state_q == ST_ACCESS) |-> ##2 o_core_done) else $error("access length wrong");

endmodule : memory_host_pin_mode_mux

// file: logic/pin_mode_pkg.sv
// constants and types shared by the memory/host pin personality block
package pin_mode_pkg;

	//--------------------------------------------------------------
	// widths
	//--------------------------------------------------------------
	localparam int ADDR_W  = 14;
	localparam int DATA_W  = 24;
	localparam int HOST_W  = 16;
	localparam int BYTE_W  = 8;
	localparam int FLAG_W  = 8;
	localparam int MEM_AW  = 8;
	localparam int REG_AW  = 4;
	localparam int HOST_LATCH_W = 15;

	//--------------------------------------------------------------
	// register offsets and fields
	//--------------------------------------------------------------
	localparam logic [3:0] OFS_CTRL     = 4'h0;
	localparam logic [3:0] OFS_FLAG_DIR = 4'h1;
	localparam logic [3:0] OFS_FLAG_OUT = 4'h2;
	localparam logic [3:0] OFS_STATUS   = 4'h3;
	localparam logic [3:0] OFS_FLAG_IN  = 4'h4;
	localparam int CTRL_PROCESSOR_CLOCK_OUTPUT_BIT = 0;
	localparam int STAT_MODE_BIT   = 0;
	localparam int STAT_GRANT_BIT  = 1;
	localparam int STAT_HANG_BIT   = 2;
	localparam int HOST_SPACE_BIT  = 14;

	//--------------------------------------------------------------
	// reset values and counts
	//--------------------------------------------------------------
	localparam logic [7:0] FLAG_DIR_RST  = 8'h00;
	localparam logic [7:0] FLAG_OUT_RST  = 8'hFF;
	localparam logic       PROCESSOR_CLOCK_OUTPUT_EN_RST = 1'b1;
	localparam logic [2:0] ACCESS_CYCLES = 3'h2;

	//--------------------------------------------------------------
	// enumerations
	//--------------------------------------------------------------
	typedef enum logic [1:0] {
		SP_PROGRAM = 2'b00,
		SP_DATA    = 2'b01,
		SP_BYTE    = 2'b10,
		SP_IO      = 2'b11
	} space_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ACCESS = 2'b01,
		ST_GRANT  = 2'b10
	} bus_state_t;

	typedef enum logic {
		MODE_FULL = 1'b0,
		MODE_HOST = 1'b1
	} mode_t;

endpackage : pin_mode_pkg

// file: tb/ext_mem_model.sv
// board-side memory model answering core reads on the external data bus
module ext_mem_model (
	// pins seen from the board
	input  wire logic        i_rd_n,
	input  wire logic        i_sel_n,
	input  wire logic [13:0] i_addr,
	output logic      [23:0] o_data
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [23:0] last_q = 24'h0;

	// answer only while a space select decodes and read is low, else show the inverse
	always_comb begin
		if (!i_rd_n && !i_sel_n) o_data = {~i_addr[9:0], i_addr};
		else o_data = ~last_q;
	end

	// remember the last word so a released bus never holds it
	always @(posedge i_rd_n) last_q <= {~i_addr[9:0], i_addr};
endmodule : ext_mem_model

// file: tb/memory_host_pin_mode_mux_bench.sv
// self-checking bench for the memory/host pin personality block
module memory_host_pin_mode_mux_bench;
	import pin_mode_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	//----------------------------------------------------------
	// signals
	//----------------------------------------------------------
	logic i_clk, i_nrst, i_memory_mode_strap, i_ack_push_pull_strap, i_core_req, i_core_write, i_reg_wr, i_reg_rd;
	logic i_bus_request_in_n, i_emulator_bus_request_n, i_emulator_enable, i_host_select_n;
	logic i_host_write_strobe_n, i_host_read_strobe_n, i_host_addr_latch, o_core_done, o_rd_n, o_wr_n;
	logic o_combined_space_select_n, o_program_space_select_n, o_data_space_select_n, o_byte_space_select_n;
	logic o_io_space_select_n, o_strobe_oe, o_bus_grant_out_n, o_bus_grant_oe, o_bus_grant_hang_out_n;
	logic o_host_addr_data_oe, o_host_ack_n, o_host_ack_oe, o_processor_clock_output, o_serial_out_oe, o_host_mode;
	space_t      i_core_space;
	logic [13:0] i_core_addr, o_external_address_out, o_external_address_oe;
	logic [23:0] i_core_wdata, o_core_rdata, o_external_data_bus, o_external_data_oe, mem_data;
	logic [15:0] o_host_addr_data_bus, host_drv;
	logic [7:0]  i_core_byte_page, o_flag_pins, o_flag_oe, flag_drv, i_reg_wdata, o_reg_rdata, rd;
	logic [3:0]  i_reg_addr;
	int          n_mismatch, num_checks;
	wire logic [23:0] i_external_data_bus = (o_external_data_oe & o_external_data_bus) | (~o_external_data_oe & mem_data);
	wire logic [15:0] i_host_addr_data_bus = o_host_addr_data_oe ? o_host_addr_data_bus : host_drv;
	wire logic [7:0]  i_flag_pins = (o_flag_oe & o_flag_pins) | (~o_flag_oe & flag_drv);

	memory_host_pin_mode_mux DUT (.*);
	ext_mem_model MEM (.i_rd_n(o_rd_n), .i_sel_n(o_combined_space_select_n & o_byte_space_select_n),
		.i_addr(o_external_address_out), .o_data(mem_data));

	always #25 i_clk = ~i_clk;

	//----------------------------------------------------------
	// helpers
	//----------------------------------------------------------
	task chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task stop_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	function automatic logic [4:0] sel_exp(input space_t s);
		case (s)
			SP_PROGRAM: return 5'h07;
			SP_DATA: return 5'h0B;
			SP_BYTE: return 5'h1D;
			default: return 5'h0E;
		endcase
	endfunction : sel_exp

	function automatic logic [4:0] sels();
		return {o_combined_space_select_n, o_program_space_select_n, o_data_space_select_n,
			o_byte_space_select_n, o_io_space_select_n};
	endfunction : sels

	task reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'h1;
		@(posedge i_clk);
		i_reg_wr <= 1'h0;
	endtask : reg_wr

	task reg_rd(input logic [3:0] a, input logic [7:0] exp, input string what);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_rd <= 1'h1;
		@(posedge i_clk);
		i_reg_rd <= 1'h0;
		#1 chk(o_reg_rdata, exp, what);
	endtask : reg_rd

	task do_reset(input logic m);
		i_nrst <= 1'h0;
		i_memory_mode_strap <= m;
		i_ack_push_pull_strap <= 1'($urandom);
		repeat (4) @(posedge i_clk);
		#1 chk(o_external_address_oe, 0, "reset addr float");
		chk(o_external_data_oe, 0, "reset data float");
		chk({sels(), o_rd_n, o_wr_n, o_strobe_oe, o_bus_grant_out_n, o_host_ack_n, o_host_ack_oe}, 24'h7FE, "reset");
		chk({o_flag_oe, o_serial_out_oe}, 24'h1, "reset dirs");
		@(posedge i_clk) i_nrst <= 1'h1;
		@(posedge i_clk) i_memory_mode_strap <= ~m;
		repeat (2) @(posedge i_clk);
	endtask : do_reset

	task core(input logic w, input space_t s);
		logic [13:0] a, m;
		logic [23:0] d, dm;
		logic [7:0] p;
		a = 14'($urandom);
		d = 24'($urandom);
		p = 8'($urandom);
		m = o_host_mode ? 14'h0001 : 14'h3FFF;
		dm = o_host_mode ? 24'hFFFF00 : 24'hFFFFFF;
		@(posedge i_clk);
		i_core_req <= 1'h1;
		i_core_write <= w;
		i_core_space <= s;
		i_core_addr <= a;
		i_core_wdata <= d;
		i_core_byte_page <= p;
		@(posedge i_clk);
		#1 chk(o_external_address_oe, m, "addr oe");
		chk(o_external_address_out & m, a & m, "addr");
		chk(sels(), sel_exp(s), "selects");
		chk({o_rd_n, o_wr_n}, {w, ~w}, "strobes");
		if (s == SP_BYTE) chk(o_external_data_bus[23:16], p, "byte page");
		else if (w) chk(o_external_data_bus & dm, d & dm, "wdata");
		if (o_host_mode) chk(o_external_data_oe[7:0], 0, "low data float");
		repeat (2) @(posedge i_clk);
		i_core_req <= 1'h0;
		#1 chk({o_core_done, sels()}, 24'h3F, "done");
		if (!w && s != SP_BYTE && !o_host_mode) chk(o_core_rdata, {~a[9:0], a}, "rdata");
	endtask : core

	task grant(input logic emu);
		@(posedge i_clk);
		i_bus_request_in_n <= emu;
		i_emulator_bus_request_n <= ~emu;
		i_emulator_enable <= emu;
		i_core_req <= 1'h1;
		@(posedge i_clk);
		#1 chk({o_bus_grant_out_n, o_bus_grant_hang_out_n, o_strobe_oe, o_bus_grant_oe}, {3'h0, ~emu}, "grant");
		chk(o_external_address_oe, 0, "grant addr float");
		chk(o_external_data_oe, 0, "grant data float");
		reg_rd(OFS_STATUS, {5'h0, 2'h3, o_host_mode}, "status grant");
		@(posedge i_clk);
		i_bus_request_in_n <= 1'h1;
		i_emulator_bus_request_n <= 1'h1;
		i_emulator_enable <= 1'h0;
		i_core_req <= 1'h0;
		repeat (2) @(posedge i_clk);
		#1 chk(o_bus_grant_out_n, 1'h1, "ungrant");
	endtask : grant

	task hlatch(input logic [15:0] v);
		@(posedge i_clk);
		i_host_addr_latch <= 1'h1;
		host_drv <= v;
		@(posedge i_clk);
		i_host_addr_latch <= 1'h0;
		host_drv <= ~v;
	endtask : hlatch

	task hword(input logic w, input logic [15:0] d, input logic drv);
		@(posedge i_clk);
		if (w) host_drv <= d;
		i_host_write_strobe_n <= ~w;
		i_host_read_strobe_n <= w;
		@(posedge i_clk);
		#1 if (drv) chk({o_host_ack_n, o_host_ack_oe}, {1'h1, i_ack_push_pull_strap}, "ack busy");
		@(posedge i_clk);
		#1 if (!w) chk(o_host_addr_data_oe, drv, "host drive");
		if (!w && drv) chk(o_host_addr_data_bus, d, "host rdata");
		if (drv) chk({o_host_ack_n, o_host_ack_oe}, 24'h1, "ack");
		@(posedge i_clk);
		i_host_write_strobe_n <= 1'h1;
		i_host_read_strobe_n <= 1'h1;
		host_drv <= ~d;
	endtask : hword

	//----------------------------------------------------------
	// tests
	//----------------------------------------------------------
	initial begin
		logic [15:0] hd0, hd1, ha;
		logic [7:0] dir, fo;
		int tog;
		logic prev;
		{i_clk, i_core_req, i_core_write, i_reg_wr, i_reg_rd, i_host_addr_latch, i_emulator_enable} = 0;
		{i_bus_request_in_n, i_emulator_bus_request_n, i_host_select_n} = 3'h7;
		{i_host_write_strobe_n, i_host_read_strobe_n} = 2'h3;
		i_core_space = SP_PROGRAM;
		{i_core_addr, i_core_wdata, i_core_byte_page, i_reg_addr, i_reg_wdata} = 0;
		host_drv = 16'h0;
		void'($urandom(77));
		flag_drv = 8'($urandom);
		do_reset(1'h0);
		reg_rd(OFS_CTRL, 8'h01, "ctrl");
		reg_rd(OFS_FLAG_DIR, FLAG_DIR_RST, "dir");
		reg_rd(OFS_FLAG_OUT, FLAG_OUT_RST, "fout");
		reg_wr(OFS_STATUS, 8'hFF);
		reg_rd(OFS_STATUS, 8'h00, "status full");
		reg_rd(4'(5 + $urandom % 11), 8'h00, "unmapped");
		dir = 8'($urandom);
		fo = 8'($urandom);
		reg_wr(OFS_FLAG_DIR, dir);
		reg_wr(OFS_FLAG_OUT, fo);
		#1 chk({o_flag_oe, o_flag_pins & dir}, {dir, fo & dir}, "flags");
		reg_rd(OFS_FLAG_IN, (fo & dir) | (flag_drv & ~dir), "flag in");
		for (int i = 0; i < 8; i++) core(1'(i), space_t'(i / 2));
		grant(1'h0);
		grant(1'h1);
		tog = 0;
		repeat (4) begin
			prev = o_processor_clock_output;
			@(posedge i_clk);
			#1 tog += (o_processor_clock_output !== prev) ? 1 : 0;
		end
		chk(24'(tog), 24'h4, "clk running");
		reg_wr(OFS_CTRL, 8'h00);
		repeat (2) @(posedge i_clk);
		repeat (4) @(negedge i_clk) chk(o_processor_clock_output, 1'h0, "clk off");
		@(posedge i_clk) i_host_select_n <= 1'h0;
		hword(1'h0, 16'h0, 1'h0);
		$display("test full mode done");
		do_reset(1'h1);
		reg_rd(OFS_STATUS, 8'h01, "status host");
		core(1'h1, SP_DATA);
		core(1'h0, SP_IO);
		ha = {1'h0, 1'($urandom), 7'h0, 7'($urandom % 126)};
		hd0 = 16'($urandom);
		hd1 = 16'($urandom);
		hlatch(ha);
		hword(1'h1, hd0, 1'h1);
		hword(1'h1, hd1, 1'h1);
		hlatch(ha);
		hword(1'h0, hd0, 1'h1);
		hword(1'h0, hd1, 1'h1);
		i_host_select_n <= 1'h1;
		hword(1'h0, hd0, 1'h0);
		$display("test host mode done");
		stop_test();
	end

	// cut a hang short
	initial begin
		#400000;
		n_mismatch++;
		stop_test();
	end
endmodule : memory_host_pin_mode_mux_bench
